/* File: common/conv_regs_pkg.sv */
// Package with register map, field layout, reset values and carrier types of the converter control bank
package conv_regs_pkg;

  // Bus geometry
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned NUM_CONV = 2;
  localparam int unsigned NUM_PINS = 3;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONV_A_CONTROL = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CONV_A_LIMITS = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CONV_B_CONTROL = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CONV_B_LIMITS = 6'h05;

  // Control register field positions
  localparam int unsigned FPWM_BIT = 4;
  localparam int unsigned DISCH_BIT = 3;
  localparam int unsigned SRC_LSB = 1;
  localparam int unsigned SRC_MSB = 2;
  localparam int unsigned EN_BIT = 0;

  // Limits register field positions
  localparam int unsigned ILIM_LSB = 3;
  localparam int unsigned ILIM_MSB = 5;
  localparam int unsigned SLEW_LSB = 0;
  localparam int unsigned SLEW_MSB = 2;

  // Values after reset
  localparam logic [REG_W-1:0] CONTROL_RST = 8'h08;
  localparam logic [REG_W-1:0] LIMITS_RST = 8'h1a;

  // Field codes
  localparam logic [1:0] SRC_SW_ONLY = 2'h0;
  localparam logic [2:0] ILIM_RESERVED = 3'h7;
  localparam logic [2:0] SLEW_LAST_RESERVED = 3'h1;

  // Power-up phase: one cycle of default loading, then service
  typedef enum logic {PH_LOAD, PH_RUN} phase_t;

  // Defaults delivered by the one-time-programmable store
  typedef struct packed {
    logic force_pwm;
    logic [1:0] enable_source;
    logic sw_enable;
    logic [2:0] peak_limit;
    logic [2:0] ramp_speed;
  } otp_default_t;

  // Controls handed to one converter's power stage
  typedef struct packed {
    logic run;
    logic force_pwm;
    logic discharge_active;
    logic [2:0] peak_limit;
    logic limit_code_bad;
    logic [2:0] ramp_speed;
    logic ramp_code_bad;
  } conv_out_t;

  localparam conv_out_t CONV_OUT_RST = '{run: 1'b0, force_pwm: 1'b0, discharge_active: 1'b1,
                                         peak_limit: 3'h3, limit_code_bad: 1'b0,
                                         ramp_speed: 3'h2, ramp_code_bad: 1'b0};

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } wb_req_t;

endpackage

/* File: rtl/conv_channel.sv */
// One converter's control and limits registers with its power-stage controls
`timescale 1ns/1ps
module conv_channel
  import conv_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Default loading
  input wire logic otp_load,
  input wire otp_default_t otp,
  // Register writes
  input wire logic wr_ctrl,
  input wire logic wr_lim,
  input wire logic [REG_W-1:0] wdata,
  // Filtered enable pins
  input wire logic [NUM_PINS-1:0] pins,
  // Register contents and converter controls
  output logic [REG_W-1:0] ctrl_q,
  output logic [REG_W-1:0] lim_q,
  output conv_out_t out
);

  logic [REG_W-1:0] next_ctrl;
  logic [REG_W-1:0] next_lim;
  conv_out_t next_out;
  logic pin_gate;

  // Register updates: default load wins, otherwise whole-byte writes
  always_comb begin
    next_ctrl = ctrl_q;
    next_lim = lim_q;
    if (otp_load) begin
      next_ctrl[FPWM_BIT] = otp.force_pwm;
      next_ctrl[SRC_MSB:SRC_LSB] = otp.enable_source;
      next_ctrl[EN_BIT] = otp.sw_enable;
      next_lim[ILIM_MSB:ILIM_LSB] = otp.peak_limit;
      next_lim[SLEW_MSB:SLEW_LSB] = otp.ramp_speed;
    end else begin
      if (wr_ctrl) begin
        next_ctrl = wdata;
      end
      if (wr_lim) begin
        next_lim = wdata;
      end
    end
  end

  // Power-stage controls follow the registers one cycle later
  always_comb begin
    if (ctrl_q[SRC_MSB:SRC_LSB] == SRC_SW_ONLY) begin
      pin_gate = 1'b1;
    end else begin
      pin_gate = pins[ctrl_q[SRC_MSB:SRC_LSB] - 2'h1];
    end
    next_out.run = ctrl_q[EN_BIT] & pin_gate;
    next_out.force_pwm = ctrl_q[FPWM_BIT];
    next_out.discharge_active = ctrl_q[DISCH_BIT] & ~next_out.run;
    // Limit is live even while running; no enable interlock
    next_out.peak_limit = lim_q[ILIM_MSB:ILIM_LSB];
    next_out.limit_code_bad = lim_q[ILIM_MSB:ILIM_LSB] == ILIM_RESERVED;
    next_out.ramp_speed = lim_q[SLEW_MSB:SLEW_LSB];
    next_out.ramp_code_bad = lim_q[SLEW_MSB:SLEW_LSB] <= SLEW_LAST_RESERVED;
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CONTROL_RST;
      lim_q <= LIMITS_RST;
      out <= CONV_OUT_RST;
    end else begin
      ctrl_q <= next_ctrl;
      lim_q <= next_lim;
      out <= next_out;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_mode_select: assert property (1'b1 |=> out.force_pwm == $past(ctrl_q[FPWM_BIT]))
    else $error("force pwm does not follow mode bit");
  a_discharge_gate: assert property (out.discharge_active |-> !out.run && $past(ctrl_q[DISCH_BIT]))
    else $error("discharge active while running or not selected");
  a_pin_gating: assert property ((ctrl_q[SRC_MSB:SRC_LSB] != SRC_SW_ONLY) && !pin_gate |=> !out.run)
    else $error("converter runs with its enable pin low");
  a_sw_enable: assert property (ctrl_q[EN_BIT] && (ctrl_q[SRC_MSB:SRC_LSB] == SRC_SW_ONLY) |=> out.run)
    else $error("software enable did not start converter");
  a_limit_live: assert property (wr_lim && !otp_load && out.run |-> ##2
                                 out.peak_limit == $past(wdata[ILIM_MSB:ILIM_LSB], 2))
    else $error("peak limit not applied while running");
  a_slew_code: assert property (wr_lim && !otp_load |-> ##2
                                (out.ramp_speed == $past(wdata[SLEW_MSB:SLEW_LSB], 2)) &&
                                (out.ramp_code_bad == ($past(wdata[SLEW_MSB:SLEW_LSB], 2) < 3'h2)))
    else $error("ramp speed or reserved flag wrong");
  a_otp_defaults: assert property (otp_load |=> ctrl_q[EN_BIT] == $past(otp.sw_enable) &&
                                   lim_q[ILIM_MSB:ILIM_LSB] == $past(otp.peak_limit) &&
                                   ctrl_q[DISCH_BIT])
    else $error("defaults not taken from programmable store");

endmodule

/* File: rtl/conv_regs.sv */
// Wishbone register bank for the two step-down converters with enable pin synchronisers
`timescale 1ns/1ps
module conv_regs
  import conv_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave
  input wire wb_req_t wb_req,
  output logic wb_ack,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  // External enable pins, asynchronous
  input wire logic ext_enable_pin_one,
  input wire logic ext_enable_pin_two,
  input wire logic ext_enable_pin_three,
  // Programmable-store defaults, steady after reset
  input wire otp_default_t conv_a_otp,
  input wire otp_default_t conv_b_otp,
  // Power-stage controls
  output conv_out_t conv_a_out,
  output conv_out_t conv_b_out
);

  // Power-up phase
  phase_t phase;
  phase_t next_phase;
  logic otp_load;

  // Pin synchronisers
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1;
  logic [NUM_PINS-1:0] pin_s2;
  logic [NUM_PINS-1:0] pin_s3;
  logic [NUM_PINS-1:0] pin_flt;
  logic [NUM_PINS-1:0] next_pin_flt;

  // Bus decode
  logic aligned;
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr_commit;
  logic mapped;
  logic [REG_W-1:0] rd_byte;
  logic next_ack;
  logic [WB_DAT_W-1:0] next_dat;

  // Per-converter wiring
  otp_default_t otp_arr [NUM_CONV];
  conv_out_t out_arr [NUM_CONV];
  logic [REG_W-1:0] ctrl_arr [NUM_CONV];
  logic [REG_W-1:0] lim_arr [NUM_CONV];
  logic [NUM_CONV-1:0] hit_ctrl;
  logic [NUM_CONV-1:0] hit_lim;

  assign pin_raw = {ext_enable_pin_three, ext_enable_pin_two, ext_enable_pin_one};
  assign otp_arr[0] = conv_a_otp;
  assign otp_arr[1] = conv_b_otp;
  assign conv_a_out = out_arr[0];
  assign conv_b_out = out_arr[1];

  // Phase: async reset cannot sample the store, so defaults load on the first clock
  always_comb begin
    case (phase)
      PH_LOAD: next_phase = PH_RUN;
      PH_RUN: next_phase = PH_RUN;
      default: next_phase = PH_LOAD;
    endcase
  end

  assign otp_load = phase == PH_LOAD;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_LOAD;
    end else begin
      phase <= next_phase;
    end
  end

  // Pin filter: a new level counts once stages two and three agree
  always_comb begin
    next_pin_flt = pin_flt;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_flt[i] = pin_s3[i];
      end
    end
  end

  // Stage one feeds only stage two, to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_flt <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_flt <= next_pin_flt;
    end
  end

  // Address decode; unaligned addresses count as unmapped
  assign aligned = wb_req.adr[1:0] == 2'h0;
  assign idx = wb_req.adr[WB_ADR_W-1:2];
  assign req = wb_req.cyc & wb_req.stb & (phase == PH_RUN);
  // Write lands on the edge where the master sees ack, lane 0 carries the byte
  assign wr_commit = req & wb_req.we & wb_ack & wb_req.sel[0];

  // Channels: one instance per converter, each with its own register indices and store defaults
  for (genvar ch = 0; ch < NUM_CONV; ch++) begin : g_conv
    localparam logic [IDX_W-1:0] CI = (ch == 0) ? IDX_CONV_A_CONTROL : IDX_CONV_B_CONTROL;
    localparam logic [IDX_W-1:0] LI = (ch == 0) ? IDX_CONV_A_LIMITS : IDX_CONV_B_LIMITS;

    assign hit_ctrl[ch] = aligned & (idx == CI);
    assign hit_lim[ch] = aligned & (idx == LI);

    conv_channel u_channel (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .otp_load(otp_load),
      .otp(otp_arr[ch]),
      .wr_ctrl(wr_commit & hit_ctrl[ch]),
      .wr_lim(wr_commit & hit_lim[ch]),
      .wdata(wb_req.dat[REG_W-1:0]),
      .pins(pin_flt),
      .ctrl_q(ctrl_arr[ch]),
      .lim_q(lim_arr[ch]),
      .out(out_arr[ch])
    );
  end

  assign mapped = (|hit_ctrl) | (|hit_lim);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_byte = '0;
    for (int c = 0; c < NUM_CONV; c++) begin
      if (hit_ctrl[c]) begin
        rd_byte = ctrl_arr[c];
      end
      if (hit_lim[c]) begin
        rd_byte = lim_arr[c];
      end
    end
  end

  // Bus answer: ack one cycle after the request, then one idle cycle
  always_comb begin
    next_ack = req & ~wb_ack;
    next_dat = wb_dat_o;
    if (req & ~wb_ack) begin
      next_dat = {{(WB_DAT_W - REG_W){1'b0}}, rd_byte};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Bus handshake sequences
  sequence s_new_req;
    req && !wb_ack;
  endsequence

  sequence s_ack_pulse;
    wb_ack ##1 !wb_ack;
  endsequence

  a_ack_timing: assert property (s_new_req |=> s_ack_pulse)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property (wb_ack |-> $past(req))
    else $error("ack without a pending request");
  a_unmapped_zero: assert property (wb_ack && !wb_req.we && !mapped |-> wb_dat_o == '0)
    else $error("unmapped read returned nonzero data");
  a_load_once: assert property ($rose(rst_b) |-> otp_load ##1 (!otp_load)[*4])
    else $error("default load not a single cycle after reset");

  // Write then read back of the same register returns the written byte
  // The master releases after ack and idles one cycle, so the read is taken two cycles after the write
  a_write_readback: assert property ((wr_commit && hit_ctrl[0]) ##2
                                     (s_new_req and (!wb_req.we && hit_ctrl[0]))
                                     |=> wb_dat_o[REG_W-1:0] == $past(wb_req.dat[REG_W-1:0], 3))
    else $error("control register read back differs from write");
  a_reserved_bits: assert property (wr_commit && hit_ctrl[1] |=> ctrl_arr[1][7:5] == $past(wb_req.dat[7:5]))
    else $error("reserved control bits of converter b not stored");

  // Same register contents must give the same controls on both converters
  a_same_layout: assert property (ctrl_arr[0] == ctrl_arr[1] && lim_arr[0] == lim_arr[1]
                                  |=> out_arr[0] == out_arr[1])
    else $error("converters decode identical registers differently");
  a_limit_code: assert property (wr_commit && hit_lim[0] |-> ##2
                                 out_arr[0].peak_limit == $past(wb_req.dat[ILIM_MSB:ILIM_LSB], 2) &&
                                 out_arr[0].limit_code_bad == ($past(wb_req.dat[ILIM_MSB:ILIM_LSB], 2) == 3'h7))
    else $error("peak limit code not applied");
  // Per pin: a bit may only move when its own stages agreed; other pins may still be settling
  a_pin_filter: assert property ($changed(pin_flt) |->
                                 ((pin_flt ^ $past(pin_flt)) & ($past(pin_s2) ^ $past(pin_s3))) == '0)
    else $error("pin level accepted before stages agreed");
  a_pin_select: assert property (ctrl_arr[0][EN_BIT] && ctrl_arr[0][SRC_MSB:SRC_LSB] == 2'h2 && pin_flt[1]
                                 |=> out_arr[0].run)
    else $error("pin two selection did not enable converter a");

endmodule

/* File: verif/conv_regs_tb.sv */
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
module conv_regs_tb import conv_regs_pkg::*;;
  // Clock, reset and bus
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  wb_req_t wb_req = '0;
  logic wb_ack;
  logic [WB_DAT_W-1:0] wb_dat_o;
  // Enable pins and store defaults
  logic [2:0] pins = 3'h0;
  otp_default_t conv_a_otp = '{force_pwm: 1'b1, enable_source: 2'h0, sw_enable: 1'b0, peak_limit: 3'h6,
                               ramp_speed: 3'h7};
  otp_default_t conv_b_otp = '{force_pwm: 1'b0, enable_source: 2'h1, sw_enable: 1'b1, peak_limit: 3'h3,
                               ramp_speed: 3'h2};
  conv_out_t conv_a_out;
  conv_out_t conv_b_out;
  // Shadow of the four registers, indexed a_control, a_limits, b_control, b_limits
  logic [7:0] shadow [4];
  int fails = 0;
  int samples_checked = 0;

  conv_regs dut_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wb_req(wb_req),
    .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o),
    .ext_enable_pin_one(pins[0]),
    .ext_enable_pin_two(pins[1]),
    .ext_enable_pin_three(pins[2]),
    .conv_a_otp(conv_a_otp),
    .conv_b_otp(conv_b_otp),
    .conv_a_out(conv_a_out),
    .conv_b_out(conv_b_out)
  );

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  // Counts first, then the verdict
  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Register read data
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Power-stage controls
  task automatic check_out(input string what, input conv_out_t exp, input conv_out_t got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected controls from register contents and pin levels
  function automatic conv_out_t exp_out(input logic [7:0] c, input logic [7:0] l, input logic [2:0] p);
    conv_out_t e;
    logic [3:0] gate;
    gate = {p, 1'b1};
    e.run = c[0] & gate[c[2:1]];
    e.force_pwm = c[4];
    e.discharge_active = c[3] & ~e.run;
    e.peak_limit = l[5:3];
    e.limit_code_bad = (l[5:3] == 3'h7);
    e.ramp_speed = l[2:0];
    e.ramp_code_bad = (l[2:0] < 3'h2);
    return e;
  endfunction

  // One classic cycle; request held until ack is sampled, bounded wait
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [7:0] data,
                          output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {24'h00_0000, data}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rdata = wb_dat_o;
    wb_req <= '0;
    if (wb_ack !== 1'b1) begin
      fails++;
      $display("MISMATCH wb_ack expected 1 seen %b", wb_ack);
      print_verdict();
    end
  endtask

  // Read one address and compare
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    wb_cycle(1'b0, adr, 4'h0, 8'h00, d);
    check_word($sformatf("read %h", adr), {24'h00_0000, exp}, d);
  endtask

  // Controls of both converters against the shadow
  task automatic check_both();
    check_out("conv_a_out", exp_out(shadow[0], shadow[1], pins), conv_a_out);
    check_out("conv_b_out", exp_out(shadow[2], shadow[3], pins), conv_b_out);
  endtask

  // Write a register, let the outputs settle, check them
  task automatic put(input int idx, input logic [7:0] data);
    logic [31:0] d;
    wb_cycle(1'b1, 8'(8 + 4 * idx), 4'h1, data, d);
    shadow[idx] = data;
    repeat (3) @(posedge clk_sys);
    check_both();
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge clk_sys);
    check_out("reset a", exp_out(8'h08, 8'h1a, 3'h0), conv_a_out);
    check_out("reset b", exp_out(8'h08, 8'h1a, 3'h0), conv_b_out);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Store defaults after release; discharge and reserved bits keep reset values
    shadow[0] = 8'h18;
    shadow[1] = 8'h37;
    shadow[2] = 8'h0b;
    shadow[3] = 8'h1a;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8 + 4 * i), shadow[i]);
    end
    check_both();
    // Every bit, reserved included, reads back; flags for reserved codes
    foreach (shadow[i]) begin
      put(i, 8'hff);
      rd(8'(8 + 4 * i), 8'hff);
      put(i, 8'h00);
      rd(8'(8 + 4 * i), 8'h00);
      put(i, 8'h5a);
      rd(8'(8 + 4 * i), 8'h5a);
    end
    // Unmapped, unaligned and byte-disabled accesses leave registers alone
    rd(8'h00, 8'h00);
    rd(8'h18, 8'h00);
    wb_cycle(1'b1, 8'h09, 4'h1, 8'hff, d);
    rd(8'h09, 8'h00);
    rd(8'h08, 8'h5a);
    wb_cycle(1'b1, 8'h0c, 4'h2, 8'hff, d);
    rd(8'h0c, 8'h5a);
    // Write followed at once by a read of the same register
    wb_cycle(1'b1, 8'h08, 4'h1, 8'h3c, d);
    shadow[0] = 8'h3c;
    rd(8'h08, 8'h3c);
    // Every enable source against every pin pattern, on both converters
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        put(2 * c, {5'b0_1000, 2'(s), 1'b1});
        for (int p = 0; p < 8; p++) begin
          @(posedge clk_sys);
          pins <= 3'(p);
          repeat (6) @(posedge clk_sys);
          check_both();
        end
      end
      put(2 * c, 8'h0e);
    end
    // Limit and slew codes changed while converter a runs
    put(0, 8'h01);
    for (int k = 0; k < 8; k++) begin
      put(1, {2'b00, 3'(k), 3'(7 - k)});
      rd(8'h0c, {2'b00, 3'(k), 3'(7 - k)});
    end
    print_verdict();
  end
endmodule
